// [hdl/epc_manager.sv]
// Extended power condition manager with APB register access
`timescale 1ns/10ps
`default_nettype none

module epc_manager #(
  parameter int TICK_CYCLES = epc_pkg::TICK_CYCLES
) (
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  output logic      [7:0]  POWER_COND,
  output logic             STANDBY_STATE
);

  localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES - 1);
  localparam int LAST = epc_pkg::NUM_COND - 1;

  localparam epc_pkg::mgr_state_type RESET_STATE = '{
    prdata:    '0,
    pready:    1'b0,
    pslverr:   1'b0,
    cur:       epc_pkg::DEF_TIMERS,
    sav:       epc_pkg::DEF_TIMERS,
    tval:      '0,
    cond:      epc_pkg::COND_IDLE_B,
    cond_id:   epc_pkg::ID_IDLE_B,
    standby:   1'b0,
    enabled:   1'b0,
    advanced_power_management:       1'b0,
    supported: 1'b1,
    abort:     1'b0,
    bg:        1'b0,
    restart:   1'b0,
    tick:      1'b0,
    tick_cnt:  '0
  };

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic [7:0] id_of(input epc_pkg::cond_type c);
    unique case (c)
      epc_pkg::COND_IDLE_B: id_of = epc_pkg::ID_IDLE_B;
      epc_pkg::COND_IDLE_C: id_of = epc_pkg::ID_IDLE_C;
      epc_pkg::COND_STBY_Y: id_of = epc_pkg::ID_STBY_Y;
      epc_pkg::COND_STBY_Z: id_of = epc_pkg::ID_STBY_Z;
    endcase
  endfunction : id_of

  // Returns {valid, index}
  function automatic logic [2:0] index_of(input logic [7:0] id);
    case (id)
      epc_pkg::ID_IDLE_B: index_of = {1'b1, epc_pkg::COND_IDLE_B};
      epc_pkg::ID_IDLE_C: index_of = {1'b1, epc_pkg::COND_IDLE_C};
      epc_pkg::ID_STBY_Y: index_of = {1'b1, epc_pkg::COND_STBY_Y};
      epc_pkg::ID_STBY_Z: index_of = {1'b1, epc_pkg::COND_STBY_Z};
      default:            index_of = 3'h0;
    endcase
  endfunction : index_of

  function automatic logic any_set(input logic [epc_pkg::NUM_COND-1:0][epc_pkg::TIMER_W-1:0] t);
    any_set = 1'b0;
    for (int i = 0; i < epc_pkg::NUM_COND; i++) begin
      any_set = any_set | (t[i] != '0);
    end
  endfunction : any_set

  // ************************************************************
  // State
  // ************************************************************
  epc_pkg::mgr_state_type st;
  epc_pkg::mgr_state_type next_st;

  epc_pkg::timer_ctl_type  [epc_pkg::NUM_COND-1:0] tctl;
  epc_pkg::timer_stat_type [epc_pkg::NUM_COND-1:0] tstat;
  logic [epc_pkg::NUM_COND-1:0] expired;
  logic                         run_timers;
  logic                         acc_wr;

  logic [31:0]       rd;
  logic              hit;
  logic [2:0]        sel;
  logic [1:0]        ix;
  logic [3:0]        op;
  logic              bad;
  epc_pkg::cond_type deep;

  assign acc_wr = PSEL & PENABLE & st.pready & PWRITE;
  assign run_timers = st.enabled & ~st.bg & st.tick;

  // ************************************************************
  // Condition timers
  // ************************************************************
  genvar g;
  for (g = 0; g < epc_pkg::NUM_COND; g++) begin : g_timer
    assign tctl[g] = '{load: st.restart, run: run_timers, value: st.cur[g]};
    assign expired[g] = tstat[g].expired;
    epc_timer u_timer (
      .clk  (CLK),
      .rst  (RST),
      .ctl  (tctl[g]),
      .stat (tstat[g])
    );
  end

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    next_st = st;
    rd = '0;
    hit = 1'b1;
    sel = index_of(PWDATA[epc_pkg::CMD_ID_LSB +: 8]);
    ix = sel[1:0];
    op = PWDATA[epc_pkg::CMD_OP_LSB +: 4];
    deep = st.cond;
    bad = 1'b0;
    next_st.pready = 1'b0;
    next_st.pslverr = 1'b0;
    next_st.restart = 1'b0;
    next_st.tick = 1'b0;

    // Tick prescaler stops with the timers so a pause loses no fraction
    if (st.enabled && !st.bg) begin
      if (st.tick_cnt == TICK_LAST) begin
        next_st.tick_cnt = '0;
        next_st.tick = 1'b1;
      end else begin
        next_st.tick_cnt = st.tick_cnt + 32'h00000001;
      end
    end

    for (int i = 0; i < epc_pkg::NUM_COND; i++) begin
      if (expired[i] && (2'(i) > deep)) begin
        deep = epc_pkg::cond_type'(2'(i));
      end
    end
    if (st.enabled) begin
      next_st.cond = deep;
    end

    // Read data prepared in setup so the access phase has no wait
    case (PADDR)
      epc_pkg::OFS_CMD:    rd = '0;
      epc_pkg::OFS_TIMER:  rd = 32'(st.tval);
      epc_pkg::OFS_STATUS: begin
        rd[epc_pkg::ST_ABORT] = st.abort;
        rd[epc_pkg::ST_ENABLED] = st.enabled;
        rd[epc_pkg::ST_APM] = st.advanced_power_management;
        rd[epc_pkg::ST_STANDBY] = st.standby;
        rd[epc_pkg::ST_PAUSED] = st.bg;
        rd[epc_pkg::ST_ID_LSB +: 8] = st.cond_id;
      end
      epc_pkg::OFS_CONFIG: rd[epc_pkg::CFG_SUPPORTED] = st.supported;
      epc_pkg::OFS_APM:    rd[epc_pkg::APM_BIT] = st.advanced_power_management;
      epc_pkg::OFS_IDENT: begin
        rd[epc_pkg::IDW_SUPPORT_BIT] = st.supported;
        rd[epc_pkg::IDW_TIMERS_BIT] = st.enabled;
      end
      epc_pkg::OFS_QUERY:  rd = 32'(st.standby ? epc_pkg::QRY_STBY : epc_pkg::QRY_IDLE);
      epc_pkg::OFS_EVENT:  rd[epc_pkg::EV_BG] = st.bg;
      default: begin
        if (PADDR[7:4] == epc_pkg::OFS_CUR[7:4]) begin
          rd = 32'(st.cur[PADDR[3:2]]);
        end else if (PADDR[7:4] == epc_pkg::OFS_SAV[7:4]) begin
          rd = 32'(st.sav[PADDR[3:2]]);
        end else begin
          hit = 1'b0;
        end
      end
    endcase
    if (PSEL && !PENABLE) begin
      next_st.pready = 1'b1;
      next_st.prdata = hit ? rd : '0;
      next_st.pslverr = ~hit;
    end

    // ************************************************************
    // Register writes
    // ************************************************************
    if (acc_wr) begin
      case (PADDR)
        epc_pkg::OFS_TIMER:  next_st.tval = PWDATA[epc_pkg::TIMER_W-1:0];
        epc_pkg::OFS_CONFIG: next_st.supported = PWDATA[epc_pkg::CFG_SUPPORTED];
        epc_pkg::OFS_APM: begin
          if (st.enabled) begin
            next_st.abort = 1'b1;
          end else begin
            next_st.abort = 1'b0;
            next_st.advanced_power_management = PWDATA[epc_pkg::APM_BIT];
          end
        end
        epc_pkg::OFS_EVENT: begin
          next_st.bg = PWDATA[epc_pkg::EV_BG];
          if (PWDATA[epc_pkg::EV_PWRCYC] && st.enabled) begin
            next_st.cur = st.sav;
            next_st.cond = epc_pkg::COND_IDLE_B;
            next_st.restart = 1'b1;
          end
          if (PWDATA[epc_pkg::EV_RESET] && st.enabled) begin
            next_st.restart = 1'b1;
          end
          if (PWDATA[epc_pkg::EV_DONE] && st.enabled) begin
            next_st.restart = 1'b1;
          end
        end
        epc_pkg::OFS_CMD: begin
          bad = !st.supported || st.advanced_power_management || !sel[2]
              || (PWDATA[epc_pkg::CMD_SUB_LSB +: 8] != epc_pkg::FEATURE_CODE)
              || (op > epc_pkg::OP_STATE);
          next_st.abort = bad;
          if (!bad) begin
            unique case (op)
              epc_pkg::OP_RESTORE: begin
                next_st.cur[ix] = PWDATA[epc_pkg::CMD_DEF_BIT] ? epc_pkg::DEF_TIMERS[ix] : st.sav[ix];
              end
              epc_pkg::OP_GOTO: begin
                next_st.cond = epc_pkg::cond_type'(ix);
              end
              epc_pkg::OP_TIMER: begin
                next_st.cur[ix] = st.tval;
              end
              epc_pkg::OP_STATE: begin
                next_st.cur[ix] = PWDATA[epc_pkg::CMD_EN_BIT] ? epc_pkg::DEF_TIMERS[ix] : '0;
              end
            endcase
            if (PWDATA[epc_pkg::CMD_SAVE_BIT] && op != epc_pkg::OP_GOTO) begin
              next_st.sav[ix] = next_st.cur[ix];
            end
            if (op != epc_pkg::OP_GOTO) begin
              next_st.enabled = any_set(next_st.cur);
            end
            next_st.restart = next_st.enabled;
          end
        end
        default: ;
      endcase
    end

    if (!any_set(next_st.cur)) begin
      next_st.enabled = 1'b0;
    end
    if (next_st.restart) begin
      next_st.tick_cnt = '0;
    end
    next_st.cond_id = id_of(next_st.cond);
    next_st.standby = (next_st.cond == epc_pkg::COND_STBY_Y) || (next_st.cond == epc_pkg::COND_STBY_Z);
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      st <= RESET_STATE;
    end else begin
      st <= next_st;
    end
  end

  assign PRDATA = st.prdata;
  assign PREADY = st.pready;
  assign PSLVERR = st.pslverr;
  assign POWER_COND = st.cond_id;
  assign STANDBY_STATE = st.standby;

  // ************************************************************
  // Checks
  // ************************************************************
  property p_apm_abort;
    @(posedge CLK) disable iff (RST)
      (acc_wr && PADDR == epc_pkg::OFS_CMD && st.advanced_power_management) |=> (st.abort && $stable(st.cur) && $stable(st.sav));
  endproperty
  a_apm_abort: assert property (p_apm_abort) else $error("subcommand not aborted under power management");

  property p_apm_lock;
    @(posedge CLK) disable iff (RST)
      (acc_wr && PADDR == epc_pkg::OFS_APM && st.enabled) |=> (st.abort && $stable(st.advanced_power_management));
  endproperty
  a_apm_lock: assert property (p_apm_lock) else $error("power management changed while timers enabled");

  property p_reserved;
    @(posedge CLK) disable iff (RST)
      (acc_wr && PADDR == epc_pkg::OFS_CMD && PWDATA[epc_pkg::CMD_OP_LSB +: 4] > epc_pkg::OP_STATE)
      |=> (st.abort && $stable(st.cur) && $stable(st.sav) && !st.restart);
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved operation not aborted");

  property p_all_zero;
    @(posedge CLK) disable iff (RST)
      st.enabled |-> any_set(st.cur);
  endproperty
  a_all_zero: assert property (p_all_zero) else $error("enabled with all timers zero");

  property p_no_rise;
    @(posedge CLK) disable iff (RST)
      !(acc_wr && (PADDR == epc_pkg::OFS_CMD || PADDR == epc_pkg::OFS_EVENT)) |=> (st.cond >= $past(st.cond));
  endproperty
  a_no_rise: assert property (p_no_rise) else $error("expiry raised power");

  property p_deepest;
    @(posedge CLK) disable iff (RST)
      (st.enabled && expired[LAST] && !acc_wr) |=> (st.cond == epc_pkg::COND_STBY_Z) ##1 STANDBY_STATE;
  endproperty
  a_deepest: assert property (p_deepest) else $error("deepest expiry not taken");

  property p_query;
    @(posedge CLK) disable iff (RST)
      (PSEL && !PENABLE && PADDR == epc_pkg::OFS_QUERY)
      |=> (PREADY && PRDATA[7:0] == ($past(st.standby) ? epc_pkg::QRY_STBY : epc_pkg::QRY_IDLE));
  endproperty
  a_query: assert property (p_query) else $error("power mode query wrong");

  property p_pwrcyc;
    @(posedge CLK) disable iff (RST)
      (acc_wr && PADDR == epc_pkg::OFS_EVENT && PWDATA[epc_pkg::EV_PWRCYC] && st.enabled)
      |=> (st.cur == $past(st.sav) && st.restart) ##1 (tstat[0].count == st.cur[0]);
  endproperty
  a_pwrcyc: assert property (p_pwrcyc) else $error("power cycle reload wrong");

  property p_reset_keep;
    @(posedge CLK) disable iff (RST)
      (acc_wr && PADDR == epc_pkg::OFS_EVENT && PWDATA[epc_pkg::EV_RESET] && !PWDATA[epc_pkg::EV_PWRCYC]
       && st.enabled && expired == '0) |=> (st.cond == $past(st.cond) && st.restart);
  endproperty
  a_reset_keep: assert property (p_reset_keep) else $error("reset moved condition");

endmodule : epc_manager

`default_nettype wire

// [hdl/epc_pkg.sv]
// Shared constants and types for the extended power condition manager
`default_nettype none

package epc_pkg;

  // ************************************************************
  // Register map (byte addresses)
  // ************************************************************
  localparam logic [7:0] OFS_CMD    = 8'h00;
  localparam logic [7:0] OFS_TIMER  = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_CONFIG = 8'h0C;
  localparam logic [7:0] OFS_APM    = 8'h10;
  localparam logic [7:0] OFS_IDENT  = 8'h14;
  localparam logic [7:0] OFS_QUERY  = 8'h18;
  localparam logic [7:0] OFS_EVENT  = 8'h1C;
  localparam logic [7:0] OFS_CUR    = 8'h20;
  localparam logic [7:0] OFS_SAV    = 8'h30;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int CMD_OP_LSB      = 0;
  localparam int CMD_ID_LSB      = 8;
  localparam int CMD_SUB_LSB     = 16;
  localparam int CMD_SAVE_BIT    = 24;
  localparam int CMD_EN_BIT      = 25;
  localparam int CMD_DEF_BIT     = 26;
  localparam int ST_ABORT        = 0;
  localparam int ST_ENABLED      = 1;
  localparam int ST_APM          = 2;
  localparam int ST_STANDBY      = 3;
  localparam int ST_PAUSED       = 4;
  localparam int ST_ID_LSB       = 8;
  localparam int CFG_SUPPORTED   = 0;
  localparam int APM_BIT         = 0;
  localparam int IDW_SUPPORT_BIT = 7;
  localparam int IDW_TIMERS_BIT  = 23;
  localparam int EV_DONE         = 0;
  localparam int EV_PWRCYC       = 1;
  localparam int EV_RESET        = 2;
  localparam int EV_BG           = 3;

  // ************************************************************
  // Codes
  // ************************************************************
  localparam logic [7:0] FEATURE_CODE = 8'h4A;
  localparam logic [3:0] OP_RESTORE   = 4'h0;
  localparam logic [3:0] OP_GOTO      = 4'h1;
  localparam logic [3:0] OP_TIMER     = 4'h2;
  localparam logic [3:0] OP_STATE     = 4'h3;
  localparam logic [7:0] ID_STBY_Z    = 8'h00;
  localparam logic [7:0] ID_STBY_Y    = 8'h01;
  localparam logic [7:0] ID_IDLE_B    = 8'h82;
  localparam logic [7:0] ID_IDLE_C    = 8'h83;
  localparam logic [7:0] QRY_IDLE     = 8'hFF;
  localparam logic [7:0] QRY_STBY     = 8'h00;

  // Code order is power rank: a larger code draws less power
  typedef enum logic [1:0] {
    COND_IDLE_B = 2'b00,
    COND_IDLE_C = 2'b01,
    COND_STBY_Y = 2'b10,
    COND_STBY_Z = 2'b11
  } cond_type;

  // ************************************************************
  // Timers
  // ************************************************************
  localparam int NUM_COND = 4;
  localparam int TIMER_W  = 16;
  localparam logic [TIMER_W-1:0] TIMER_ONE = 16'h0001;
  // Power-on defaults, index order idle_b, idle_c, stby_y, stby_z
  localparam logic [NUM_COND-1:0][TIMER_W-1:0] DEF_TIMERS = {16'h0258, 16'h0096, 16'h0032, 16'h0001};
  localparam int TICK_TIME_MS = 100;
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_CYCLES = TICK_TIME_MS * 1000000 / CLK_PERIOD_NS;

  typedef struct packed {
    logic               load;
    logic               run;
    logic [TIMER_W-1:0] value;
  } timer_ctl_type;

  typedef struct packed {
    logic [TIMER_W-1:0] count;
    logic               armed;
    logic               expired;
  } timer_stat_type;

  typedef struct packed {
    logic [31:0]                      prdata;
    logic                             pready;
    logic                             pslverr;
    logic [NUM_COND-1:0][TIMER_W-1:0] cur;
    logic [NUM_COND-1:0][TIMER_W-1:0] sav;
    logic [TIMER_W-1:0]               tval;
    cond_type                         cond;
    logic [7:0]                       cond_id;
    logic                             standby;
    logic                             enabled;
    logic                             advanced_power_management;
    logic                             supported;
    logic                             abort;
    logic                             bg;
    logic                             restart;
    logic                             tick;
    logic [31:0]                      tick_cnt;
  } mgr_state_type;

endpackage : epc_pkg

`default_nettype wire

// [hdl/epc_timer.sv]
// Countdown timer for one power condition
`timescale 1ns/10ps
`default_nettype none

module epc_timer (
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire epc_pkg::timer_ctl_type  ctl,
  output var  epc_pkg::timer_stat_type stat
);

  epc_pkg::timer_stat_type next_stat;

  // ************************************************************
  // Count down
  // ************************************************************
  always_comb begin
    next_stat = stat;
    next_stat.expired = 1'b0;
    if (ctl.load) begin
      next_stat.count = ctl.value;
      next_stat.armed = (ctl.value != '0);
    end else if (ctl.run && stat.armed) begin
      if (stat.count == epc_pkg::TIMER_ONE) begin
        next_stat.expired = 1'b1;
        next_stat.armed = 1'b0;
        next_stat.count = '0;
      end else begin
        next_stat.count = stat.count - epc_pkg::TIMER_ONE;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      stat <= '0;
    end else begin
      stat <= next_stat;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  property p_zero_off;
    @(posedge clk) disable iff (rst)
      (ctl.load && ctl.value == '0) |=> (!stat.armed && !stat.expired);
  endproperty
  a_zero_off: assert property (p_zero_off) else $error("zero timer armed");

  property p_frozen;
    @(posedge clk) disable iff (rst)
      (stat.armed && !ctl.run && !ctl.load) |=> ($stable(stat.count) && !stat.expired);
  endproperty
  a_frozen: assert property (p_frozen) else $error("paused timer moved");

endmodule : epc_timer

`default_nettype wire

// [dv/epc_host.sv]
// Host model issuing register transfers over APB
`timescale 1ns/10ps
`default_nettype none

module epc_host (
  input  wire logic        CLK,
  input  wire logic        PREADY,
  output logic             PSEL,
  output logic             PENABLE,
  output logic             PWRITE,
  output logic      [7:0]  PADDR,
  output logic      [31:0] PWDATA
);
  // ****
  // Transfer
  // ****
  initial begin
    PSEL    = 1'b0;
    PENABLE = 1'b0;
    PWRITE  = 1'b0;
    PADDR   = 8'h00;
    PWDATA  = 32'h00000000;
  end

  // Every change follows a rising edge; ready is sampled at a rising edge
  task automatic xfer(input logic wr, input logic [7:0] adr, input logic [31:0] dat, output bit ok);
    int n;
    // Idle edge first, so back-to-back calls never drive one signal twice in a step
    @(posedge CLK);
    PSEL    <= 1'b1;
    PWRITE  <= wr;
    PADDR   <= adr;
    PWDATA  <= dat;
    @(posedge CLK);
    PENABLE <= 1'b1;
    n = 0;
    do begin
      @(posedge CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 50);
    ok = (PREADY === 1'b1);
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
    // Released data never repeats the last value
    PWDATA  <= ~dat;
  endtask : xfer
endmodule : epc_host

`default_nettype wire

// [dv/extended_power_condition_manager_test.sv]
// Self-checking bench for the extended power condition manager
`timescale 1ns/10ps
`default_nettype none

module extended_power_condition_manager_test;
  // ****
  // Bench
  // ****
  localparam logic [7:0] F = epc_pkg::FEATURE_CODE;
  logic        clk;
  logic        rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [7:0]  power_cond;
  logic        standby_state;
  logic [32:0] exp_q[$];
  logic [15:0] t;
  logic [7:0]  ids[4] = '{8'h82, 8'h83, 8'h01, 8'h00};
  logic [7:0]  bad[3] = '{8'h81, 8'hFF, 8'h02};
  int          seed = 21330;
  int          n_mismatch = 0;
  int          checked = 0;

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  epc_manager #(.TICK_CYCLES(4)) dut (.CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .POWER_COND(power_cond), .STANDBY_STATE(standby_state));
  epc_host host (.CLK(clk), .PREADY(pready), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata));

  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic test_done;
    $display("Mismatches %0d, comparisons %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : test_done

  // Read results are compared by this watcher, oldest note first
  always @(negedge clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      if (exp_q.size() == 0)
        chk(33'h1FFFFFFFF, 33'h0);
      else
        chk({pslverr, prdata}, exp_q.pop_front());
    end
  end

  task automatic op(input logic wr, input logic [7:0] a, input logic [31:0] d);
    bit ok;
    host.xfer(wr, a, d, ok);
    if (!ok) begin
      chk(33'h0, 33'h1);
      test_done();
    end
  endtask : op

  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    op(1'b0, a, 32'h0);
  endtask : rd

  // Flags are {use default, enable, save}; status word checked right after
  task automatic cmd(input logic [7:0] sub, input logic [3:0] o, input logic [7:0] id, input logic [2:0] fl,
                     input logic [15:0] st);
    op(1'b1, epc_pkg::OFS_CMD, {5'h00, fl, sub, id, 4'h0, o});
    rd(epc_pkg::OFS_STATUS, {17'h00000, st});
  endtask : cmd

  task automatic tmr(input logic [7:0] id, input logic [15:0] v, input logic [2:0] fl, input logic [15:0] st);
    op(1'b1, epc_pkg::OFS_TIMER, {16'h0000, v});
    cmd(F, epc_pkg::OP_TIMER, id, fl, st);
  endtask : tmr

  // Any condition other than the start or the target fails at once
  task automatic wait_cond(input logic [7:0] c, input logic [7:0] prev);
    int n;
    n = 0;
    while (power_cond !== c && n < 3000) begin
      @(negedge clk);
      if (power_cond !== c && power_cond !== prev) n = 3000;
      n++;
    end
    chk({24'h0, standby_state, power_cond}, {24'h0, c[7:1] == 7'h00, c});
    if (n >= 3000) test_done();
    @(posedge clk);
  endtask : wait_cond

  initial begin
    rst = 1'b1;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk({24'h0, standby_state, power_cond}, {25'h0, epc_pkg::ID_IDLE_B});
    rd(epc_pkg::OFS_CONFIG, 33'h1);
    rd(epc_pkg::OFS_IDENT, 33'h80);
    for (int i = 0; i < 4; i++) rd(epc_pkg::OFS_CUR + 8'(4 * i), {17'h0, epc_pkg::DEF_TIMERS[i]});
    rd(8'h40, {1'b1, 32'h0});
    $display("Reset values done");
    op(1'b1, epc_pkg::OFS_TIMER, 32'h9);
    cmd(8'h4B, epc_pkg::OP_TIMER, 8'h82, 3'h0, 16'h8201);
    cmd(F, 4'h4 + 4'($unsigned($random(seed)) % 12), 8'h82, 3'h0, 16'h8201);
    for (int i = 0; i < 3; i++) cmd(F, epc_pkg::OP_TIMER, bad[i], 3'h0, 16'h8201);
    op(1'b1, epc_pkg::OFS_CONFIG, 32'h0);
    cmd(F, epc_pkg::OP_TIMER, 8'h82, 3'h0, 16'h8201);
    op(1'b1, epc_pkg::OFS_CONFIG, 32'h1);
    rd(epc_pkg::OFS_CUR, {17'h0, epc_pkg::DEF_TIMERS[0]});
    $display("Refusals done");
    t = 16'h8000 | 16'($random(seed));
    tmr(8'h01, t, 3'h1, 16'h8202);
    rd(epc_pkg::OFS_CUR + 8'h8, {17'h0, t});
    rd(epc_pkg::OFS_SAV + 8'h8, {17'h0, t});
    rd(epc_pkg::OFS_IDENT, 33'h800080);
    rd(epc_pkg::OFS_QUERY, 33'hFF);
    tmr(8'h01, 16'h0, 3'h0, 16'h8202);
    tmr(8'h00, 16'h6, 3'h0, 16'h8202);
    tmr(8'h83, 16'h2, 3'h0, 16'h8202);
    wait_cond(8'h83, 8'h82);
    wait_cond(8'h00, 8'h83);
    rd(epc_pkg::OFS_QUERY, 33'h0);
    cmd(F, epc_pkg::OP_GOTO, 8'h01, 3'h0, 16'h010A);
    wait_cond(8'h00, 8'h01);
    // Value staged early so the timer restart beats the low-power idle expiry
    op(1'b1, epc_pkg::OFS_TIMER, 32'h2);
    cmd(F, epc_pkg::OP_GOTO, 8'h82, 3'h0, 16'h8202);
    cmd(F, epc_pkg::OP_TIMER, 8'h00, 3'h0, 16'h8202);
    wait_cond(8'h00, 8'h82);
    $display("Timer expiry done");
    cmd(F, epc_pkg::OP_GOTO, 8'h82, 3'h0, 16'h8202);
    // Completion events keep restarting the timers, so nothing expires
    repeat (3) op(1'b1, epc_pkg::OFS_EVENT, 32'h1);
    rd(epc_pkg::OFS_STATUS, 33'h8202);
    op(1'b1, epc_pkg::OFS_EVENT, 32'h8);
    repeat (40) @(posedge clk);
    rd(epc_pkg::OFS_STATUS, 33'h8212);
    op(1'b1, epc_pkg::OFS_EVENT, 32'h0);
    wait_cond(8'h00, 8'h82);
    op(1'b1, epc_pkg::OFS_EVENT, 32'h4);
    rd(epc_pkg::OFS_STATUS, 33'h000A);
    op(1'b1, epc_pkg::OFS_EVENT, 32'h2);
    rd(epc_pkg::OFS_STATUS, 33'h8202);
    rd(epc_pkg::OFS_CUR + 8'h8, {17'h0, t});
    rd(epc_pkg::OFS_CUR + 8'h4, {17'h0, epc_pkg::DEF_TIMERS[1]});
    cmd(F, epc_pkg::OP_RESTORE, 8'h01, 3'h4, 16'h8202);
    rd(epc_pkg::OFS_CUR + 8'h8, {17'h0, epc_pkg::DEF_TIMERS[2]});
    cmd(F, epc_pkg::OP_RESTORE, 8'h01, 3'h0, 16'h8202);
    rd(epc_pkg::OFS_CUR + 8'h8, {17'h0, t});
    $display("Events done");
    op(1'b1, epc_pkg::OFS_APM, 32'h1);
    rd(epc_pkg::OFS_STATUS, 33'h8203);
    rd(epc_pkg::OFS_APM, 33'h0);
    for (int i = 0; i < 4; i++) cmd(F, epc_pkg::OP_STATE, ids[i], 3'h0, (i == 3) ? 16'h8200 : 16'h8202);
    rd(epc_pkg::OFS_IDENT, 33'h80);
    cmd(F, epc_pkg::OP_STATE, 8'h83, 3'h2, 16'h8202);
    rd(epc_pkg::OFS_CUR + 8'h4, {17'h0, epc_pkg::DEF_TIMERS[1]});
    cmd(F, epc_pkg::OP_STATE, 8'h83, 3'h0, 16'h8200);
    op(1'b1, epc_pkg::OFS_APM, 32'h1);
    rd(epc_pkg::OFS_STATUS, 33'h8204);
    tmr(8'h82, 16'h5, 3'h0, 16'h8205);
    op(1'b1, epc_pkg::OFS_APM, 32'h0);
    $display("Power management exclusion done");
    test_done();
  end
endmodule : extended_power_condition_manager_test

`default_nettype wire
